// >>> rtl/iqda_top.sv
// The register offsets and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
module iqda_top
   import iqda_pkg::*;
(
   input wire logic CORE_CLK_I, // Multiplied core clock.
   input wire logic RST_I, // Synchronous reset, active high.
   input wire logic TX_FRAME_STROBE_I, // Frame strobe from the source.
   input wire logic [11:0] DATA_I, // Input data bus.
   input wire logic PLL_LOCKED_I, // Clock multiplier is locked.
   output logic [11:0] I_DATA_O, // Assembled I sample.
   output logic [11:0] Q_DATA_O, // Assembled Q sample.
   output logic IQ_VALID_O, // Pair pulse.
   output logic OVERFLOW_O, // Sticky interpolator overflow.
   input wire logic [iqda_pkg::ADDR_W-1:0] S_AXI_AWADDR_I, // Write address.
   input wire logic S_AXI_AWVALID_I, // Write address valid.
   output logic S_AXI_AWREADY_O, // Write address ready.
   input wire logic [31:0] S_AXI_WDATA_I, // Write data.
   input wire logic [3:0] S_AXI_WSTRB_I, // Write byte strobes.
   input wire logic S_AXI_WVALID_I, // Write data valid.
   output logic S_AXI_WREADY_O, // Write data ready.
   output logic [1:0] S_AXI_BRESP_O, // Write response.
   output logic S_AXI_BVALID_O, // Write response valid.
   input wire logic S_AXI_BREADY_I, // Write response ready.
   input wire logic [iqda_pkg::ADDR_W-1:0] S_AXI_ARADDR_I, // Read address.
   input wire logic S_AXI_ARVALID_I, // Read address valid.
   output logic S_AXI_ARREADY_O, // Read address ready.
   output logic [31:0] S_AXI_RDATA_O, // Read data.
   output logic [1:0] S_AXI_RRESP_O, // Read response.
   output logic S_AXI_RVALID_O, // Read data valid.
   input wire logic S_AXI_RREADY_I // Read data ready.
);
   import iqda_pkg::*;

   logic aw_hold_reg;
   logic w_hold_reg;
   logic [5:0] wr_idx_reg;
   logic [31:0] wdata_reg;
   logic [3:0] wstrb_reg;
   logic wr_en;
   logic wr_ok;
   logic [5:0] rd_idx;
   logic cont_reg;
   logic hb3_byp_reg;
   logic [5:0] n_reg;
   iqda_fmt_e fmt_reg;
   logic cmd_rst;
   logic overflow_reg;
   iqda_sync_e state_reg;
   logic strobe_prev_reg;
   logic rise;
   logic [8:0] low_cnt_reg;
   logic [7:0] sample_period;
   logic [7:0] word_period;
   logic take;
   logic zero_feed;
   logic pair;
   logic [11:0] pair_i;
   logic [11:0] pair_q;

   // Write channel: address and data are held separately, then applied together.
   always_ff @(posedge CORE_CLK_I) begin
      if (RST_I) begin
         aw_hold_reg <= 1'b0;
         w_hold_reg <= 1'b0;
         wr_idx_reg <= 6'h00;
         wdata_reg <= 32'h0000_0000;
         wstrb_reg <= 4'h0;
         S_AXI_AWREADY_O <= 1'b1;
         S_AXI_WREADY_O <= 1'b1;
         S_AXI_BVALID_O <= 1'b0;
         S_AXI_BRESP_O <= RESP_OKAY;
      end else begin
         if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
            aw_hold_reg <= 1'b1;
            wr_idx_reg <= S_AXI_AWADDR_I[ADDR_W-1:2];
            S_AXI_AWREADY_O <= 1'b0;
         end
         if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
            w_hold_reg <= 1'b1;
            wdata_reg <= S_AXI_WDATA_I;
            wstrb_reg <= S_AXI_WSTRB_I;
            S_AXI_WREADY_O <= 1'b0;
         end
         if (wr_en) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            S_AXI_BVALID_O <= 1'b1;
            S_AXI_BRESP_O <= wr_ok ? RESP_OKAY : RESP_SLVERR;
         end
         if (S_AXI_BVALID_O && S_AXI_BREADY_I) begin
            S_AXI_BVALID_O <= 1'b0;
            S_AXI_AWREADY_O <= 1'b1;
            S_AXI_WREADY_O <= 1'b1;
         end
      end
   end

   assign wr_en = aw_hold_reg && w_hold_reg && !S_AXI_BVALID_O;
   assign wr_ok = (wr_idx_reg == IDX_CTRL) || (wr_idx_reg == IDX_HB) || (wr_idx_reg == IDX_FMT)
      || (wr_idx_reg == IDX_STAT) || (wr_idx_reg == IDX_CMD);
   assign cmd_rst = wr_en && (wr_idx_reg == IDX_CMD) && wstrb_reg[0] && wdata_reg[CMD_RST_BIT];

   // Configuration registers; a reserved format code behaves as full word.
   always_ff @(posedge CORE_CLK_I) begin
      if (RST_I) begin
         cont_reg <= CONT_RST;
         hb3_byp_reg <= HB3_BYP_RST;
         n_reg <= N_RST;
         fmt_reg <= IQDA_FULL;
      end else if (wr_en && wstrb_reg[0]) begin
         if (wr_idx_reg == IDX_CTRL) begin
            cont_reg <= wdata_reg[CONT_BIT];
         end
         if (wr_idx_reg == IDX_HB) begin
            hb3_byp_reg <= wdata_reg[HB3_BYP_BIT];
         end
         if (wr_idx_reg == IDX_FMT) begin
            n_reg <= (wdata_reg[FMT_N_LSB +: 6] < N_MIN) ? N_MIN : wdata_reg[FMT_N_LSB +: 6];
         end
      end
      if (!RST_I && wr_en && wstrb_reg[1] && wr_idx_reg == IDX_FMT) begin
         fmt_reg <= (wdata_reg[FMT_SEL_LSB +: 2] == IQDA_QUARTER) ? IQDA_QUARTER
            : (wdata_reg[FMT_SEL_LSB +: 2] == IQDA_HALF) ? IQDA_HALF : IQDA_FULL;
      end
   end

   // Read channel answers one cycle after the address is taken.
   assign rd_idx = S_AXI_ARADDR_I[ADDR_W-1:2];
   always_ff @(posedge CORE_CLK_I) begin
      if (RST_I) begin
         S_AXI_ARREADY_O <= 1'b1;
         S_AXI_RVALID_O <= 1'b0;
         S_AXI_RDATA_O <= 32'h0000_0000;
         S_AXI_RRESP_O <= RESP_OKAY;
      end else if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
         S_AXI_ARREADY_O <= 1'b0;
         S_AXI_RVALID_O <= 1'b1;
         S_AXI_RRESP_O <= RESP_OKAY;
         S_AXI_RDATA_O <= 32'h0000_0000;
         unique case (rd_idx)
            IDX_CTRL: S_AXI_RDATA_O[CONT_BIT] <= cont_reg;
            IDX_HB: S_AXI_RDATA_O[HB3_BYP_BIT] <= hb3_byp_reg;
            IDX_FMT: begin
               S_AXI_RDATA_O[FMT_N_LSB +: 6] <= n_reg;
               S_AXI_RDATA_O[FMT_SEL_LSB +: 2] <= fmt_reg;
            end
            IDX_STAT: begin
               S_AXI_RDATA_O[STAT_OVF_BIT] <= overflow_reg;
               S_AXI_RDATA_O[STAT_IDLE_BIT] <= (state_reg == ST_IDLE);
               S_AXI_RDATA_O[STAT_LOCK_BIT] <= PLL_LOCKED_I;
            end
            IDX_CMD: S_AXI_RDATA_O <= 32'h0000_0000;
            default: S_AXI_RRESP_O <= RESP_SLVERR;
         endcase
      end else if (S_AXI_RVALID_O && S_AXI_RREADY_I) begin
         S_AXI_RVALID_O <= 1'b0;
         S_AXI_ARREADY_O <= 1'b1;
      end
   end

   // One sample is 2HN core cycles; a bus word is that divided by I.
   // The source keeps the reference a whole fraction of this.
   always_comb begin
      sample_period = hb3_byp_reg ? {1'b0, n_reg, 1'b0} : {n_reg, 2'b00};
      unique case (fmt_reg)
         IQDA_HALF: word_period = sample_period >> 1;
         IQDA_QUARTER: word_period = sample_period >> 2;
         default: word_period = sample_period;
      endcase
   end

   always_ff @(posedge CORE_CLK_I) begin
      if (RST_I) begin
         strobe_prev_reg <= 1'b0;
      end else begin
         strobe_prev_reg <= TX_FRAME_STROBE_I;
      end
   end
   assign rise = TX_FRAME_STROBE_I && !strobe_prev_reg;

   // Strobe tracking: a rise enters run, a low longer than one sample goes idle.
   always_ff @(posedge CORE_CLK_I) begin
      if (RST_I || cmd_rst) begin
         state_reg <= ST_IDLE;
         low_cnt_reg <= 9'h000;
      end else if (rise) begin
         state_reg <= ST_RUN;
         low_cnt_reg <= 9'h000;
      end else if (!TX_FRAME_STROBE_I) begin
         if (low_cnt_reg <= {1'b0, sample_period}) begin
            low_cnt_reg <= low_cnt_reg + 9'h001;
         end
         unique case (state_reg)
            ST_RUN: state_reg <= ST_GAP;
            ST_GAP: state_reg <= (low_cnt_reg >= {1'b0, sample_period}) ? ST_IDLE : ST_GAP;
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // Continuous mode never substitutes zeros.
   assign zero_feed = !cont_reg && (state_reg == ST_IDLE);

   iqda_word_timer u_timer (
      .clk_i(CORE_CLK_I),
      .rst_i(RST_I),
      .restart_i(rise || cmd_rst),
      .period_i(word_period),
      .take_o(take)
   );

   iqda_assembler u_asm (
      .clk_i(CORE_CLK_I),
      .rst_i(RST_I),
      .clear_i(rise || cmd_rst),
      .take_i(take),
      .fmt_i(cont_reg ? IQDA_FULL : fmt_reg),
      .bus_i(DATA_I),
      .zero_i(zero_feed),
      .use_level_i(cont_reg),
      .level_i_i(TX_FRAME_STROBE_I),
      .pair_o(pair),
      .i_o(pair_i),
      .q_o(pair_q)
   );

   // Nonzero continuous data while the multiplier is unlocked corrupts the
   // interpolator; only RST_I or the reset command clears it, and a new hit wins.
   always_ff @(posedge CORE_CLK_I) begin
      if (RST_I) begin
         overflow_reg <= 1'b0;
      end else if (cont_reg && !PLL_LOCKED_I && pair && (pair_i != 12'h000 || pair_q != 12'h000)) begin
         overflow_reg <= 1'b1;
      end else if (cmd_rst) begin
         overflow_reg <= 1'b0;
      end
   end

   always_ff @(posedge CORE_CLK_I) begin
      if (RST_I) begin
         I_DATA_O <= 12'h000;
         Q_DATA_O <= 12'h000;
         IQ_VALID_O <= 1'b0;
         OVERFLOW_O <= 1'b0;
      end else begin
         IQ_VALID_O <= pair;
         OVERFLOW_O <= overflow_reg;
         if (pair) begin
            I_DATA_O <= pair_i;
            Q_DATA_O <= pair_q;
         end
      end
   end

   // Helper counters for the checks below.
   logic [8:0] since_rise_reg;
   logic [8:0] since_take_reg;
   logic take_seen_reg;
   logic [9:0] idle_cnt_reg;
   logic span_ok_reg;
   logic [7:0] wp_prev_reg;
   always_ff @(posedge CORE_CLK_I) begin
      if (RST_I || rise || cmd_rst) begin
         since_rise_reg <= 9'h000;
         take_seen_reg <= 1'b0;
      end else begin
         if (since_rise_reg != 9'h1FF) begin
            since_rise_reg <= since_rise_reg + 9'h001;
         end
         if (take) begin
            take_seen_reg <= 1'b1;
         end
      end
      if (RST_I || take) begin
         since_take_reg <= 9'h000;
      end else if (since_take_reg != 9'h1FF) begin
         since_take_reg <= since_take_reg + 9'h001;
      end
      if (RST_I || state_reg != ST_IDLE || cont_reg) begin
         idle_cnt_reg <= 10'h000;
      end else if (idle_cnt_reg != 10'h3FF) begin
         idle_cnt_reg <= idle_cnt_reg + 10'h001;
      end
      wp_prev_reg <= word_period;
      span_ok_reg <= !(RST_I || rise || cmd_rst || word_period != wp_prev_reg) && (span_ok_reg || take);
   end

   default clocking cb @(posedge CORE_CLK_I); endclocking
   default disable iff (RST_I);

   sequence s_write_to(logic [5:0] idx);
      wr_en && wr_idx_reg == idx && wstrb_reg[0];
   endsequence

   property p_cont_bit;
      s_write_to(IDX_CTRL) |=> cont_reg == $past(wdata_reg[CONT_BIT]);
   endproperty
   a_cont_bit: assert property (p_cont_bit) else $error("control bit 6 not taken");

   property p_hb3_bit;
      s_write_to(IDX_HB) |=> hb3_byp_reg == $past(wdata_reg[HB3_BYP_BIT]);
   endproperty
   a_hb3_bit: assert property (p_hb3_bit) else $error("bypass bit not taken");

   property p_resync;
      rise && !cmd_rst |=> state_reg == ST_RUN ##1 since_rise_reg == 9'h001;
   endproperty
   a_resync: assert property (p_resync) else $error("no resync on strobe rise");

   property p_mid_take;
      take && !take_seen_reg |-> since_rise_reg == {1'b0, word_period >> 1};
   endproperty
   a_mid_take: assert property (p_mid_take) else $error("first capture not mid word");

   property p_word_spacing;
      take && span_ok_reg && $stable(word_period) |-> since_take_reg + 9'h001 == {1'b0, word_period};
   endproperty
   a_word_spacing: assert property (p_word_spacing) else $error("capture spacing wrong");

   property p_idle_zero;
      IQ_VALID_O && idle_cnt_reg > {1'b0, sample_period, 1'b0} + 10'h008 |-> I_DATA_O == 12'h000
         && Q_DATA_O == 12'h000;
   endproperty
   a_idle_zero: assert property (p_idle_zero) else $error("idle burst did not feed zeros");

   property p_ovf_sticky;
      overflow_reg && !cmd_rst |=> overflow_reg ##1 OVERFLOW_O;
   endproperty
   a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow did not persist");

   property p_reset_state;
      $fell(RST_I) |-> state_reg == ST_IDLE && !cont_reg;
   endproperty
   a_reset_state: assert property (@(posedge CORE_CLK_I) p_reset_state) else $error("bad state after reset");

   property p_bvalid_hold;
      S_AXI_BVALID_O && !S_AXI_BREADY_I |=> S_AXI_BVALID_O && $stable(S_AXI_BRESP_O);
   endproperty
   a_bvalid_hold: assert property (p_bvalid_hold) else $error("write response dropped");
endmodule // iqda_top

// >>> rtl/iqda_pkg.sv
package iqda_pkg;
   // Register indices; the byte address of each is four times its index.
   localparam logic [5:0] IDX_CTRL = 6'h01;
   localparam logic [5:0] IDX_HB = 6'h06;
   localparam logic [5:0] IDX_FMT = 6'h20;
   localparam logic [5:0] IDX_STAT = 6'h21;
   localparam logic [5:0] IDX_CMD = 6'h22;
   localparam int ADDR_W = 8;
   // Field positions.
   localparam int CONT_BIT = 6;
   localparam int HB3_BYP_BIT = 0;
   localparam int FMT_N_LSB = 0;
   localparam int FMT_SEL_LSB = 8;
   localparam int STAT_OVF_BIT = 0;
   localparam int STAT_IDLE_BIT = 1;
   localparam int STAT_LOCK_BIT = 2;
   localparam int CMD_RST_BIT = 0;
   // Values after reset, the smallest N and the bus response codes.
   localparam logic CONT_RST = 1'b0;
   localparam logic HB3_BYP_RST = 1'b0;
   localparam logic [5:0] N_RST = 6'h02;
   localparam logic [5:0] N_MIN = 6'h02;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [1:0] {
      IQDA_FULL = 2'b00,
      IQDA_HALF = 2'b01,
      IQDA_QUARTER = 2'b11
   } iqda_fmt_e;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_RUN = 2'b01,
      ST_GAP = 2'b11
   } iqda_sync_e;
endpackage

// >>> rtl/iqda_word_timer.sv
`timescale 1ns/1ns
module iqda_word_timer
   import iqda_pkg::*;
(
   input wire logic clk_i, // Core clock.
   input wire logic rst_i, // Synchronous reset.
   input wire logic restart_i, // Resynchronise the word phase.
   input wire logic [7:0] period_i, // Core cycles per bus word.
   output logic take_o // Mid-word capture pulse.
);
   logic [7:0] phase_reg;

   // The phase restarts at zero one cycle after the restart request.
   always_ff @(posedge clk_i) begin
      if (rst_i || restart_i) begin
         phase_reg <= 8'h00;
      end else if (phase_reg >= period_i - 8'h01) begin
         phase_reg <= 8'h00;
      end else begin
         phase_reg <= phase_reg + 8'h01;
      end
   end

   assign take_o = !rst_i && !restart_i && (phase_reg == (period_i >> 1));
endmodule // iqda_word_timer

// >>> rtl/iqda_assembler.sv
`timescale 1ns/1ns
module iqda_assembler
   import iqda_pkg::*;
(
   input wire logic clk_i, // Core clock.
   input wire logic rst_i, // Synchronous reset.
   input wire logic clear_i, // Start a new I/Q pair.
   input wire logic take_i, // Capture the bus now.
   input wire iqda_pkg::iqda_fmt_e fmt_i, // Word format.
   input wire logic [11:0] bus_i, // Input data bus.
   input wire logic zero_i, // Feed zeros instead of the bus.
   input wire logic use_level_i, // Strobe level picks I or Q.
   input wire logic level_i_i, // Strobe high marks an I word.
   output logic pair_o, // One-cycle pair pulse.
   output logic [11:0] i_o, // Assembled I.
   output logic [11:0] q_o // Assembled Q.
);
   logic [11:0] acc_reg;
   logic [11:0] i_hold_reg;
   logic [2:0] cnt_reg;
   logic have_i_reg;
   logic [2:0] ppw_m1;
   logic [11:0] word;
   logic last_piece;
   logic is_q;

   always_comb begin
      ppw_m1 = use_level_i ? 3'h0 : (fmt_i == IQDA_HALF) ? 3'h1 : (fmt_i == IQDA_QUARTER) ? 3'h3 : 3'h0;
      last_piece = (cnt_reg & ppw_m1) == ppw_m1;
      is_q = use_level_i ? !level_i_i : (cnt_reg > ppw_m1);
      unique case (fmt_i)
         IQDA_HALF: word = {acc_reg[5:0], bus_i[11:6]};
         IQDA_QUARTER: word = {acc_reg[8:0], bus_i[11:9]};
         default: word = bus_i;
      endcase
      // A burst strobe that is low at an I piece means the burst is over, so the bus is not trusted.
      if (zero_i || (!use_level_i && !level_i_i && !is_q)) begin
         word = 12'h000;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || clear_i) begin
         acc_reg <= 12'h000;
         cnt_reg <= 3'h0;
         have_i_reg <= 1'b0;
         i_hold_reg <= 12'h000;
      end else if (take_i) begin
         acc_reg <= word;
         cnt_reg <= (is_q && last_piece) ? 3'h0 : cnt_reg + 3'h1;
         if (last_piece && !is_q) begin
            i_hold_reg <= word;
            have_i_reg <= 1'b1;
         end else if (last_piece) begin
            have_i_reg <= 1'b0;
         end
      end
   end

   // Both halves leave together, so I and Q are time aligned.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pair_o <= 1'b0;
         i_o <= 12'h000;
         q_o <= 12'h000;
      end else begin
         pair_o <= take_i && !clear_i && last_piece && is_q && (have_i_reg || !use_level_i);
         if (take_i && last_piece && is_q) begin
            i_o <= i_hold_reg;
            q_o <= word;
         end
      end
   end
endmodule // iqda_assembler

// >>> tb/iqda_src_model.sv
`timescale 1ns/1ns
module iqda_src_model (
   input wire logic clk_i, // Core clock shared with the assembler.
   output logic strobe_o, // Frame strobe.
   output logic [11:0] data_o // Input data bus.
);
   initial begin
      strobe_o = 1'b0;
      data_o = 12'h0A5;
   end
   // Sends np pairs with whole-cycle word periods, so the word rate stays an integer divisor.
   // A lo of zero keeps the strobe low for each whole Q word, a positive lo drops it lo cycles
   // into each Q word, and a negative lo keeps it high for the whole frame.
   task automatic send(input logic [1:0] fmt, input int w, input int lo, input logic [11:0] i0,
                       input logic [11:0] q0, input int np);
      int bw;
      logic [11:0] v;
      bw = (fmt == 2'b00) ? 12 : (fmt == 2'b01) ? 6 : 3;
      for (int k = 0; k < np; k++) begin
         for (int h = 0; h < 2; h++) begin
            v = h ? q0 + 12'(k * 12'h321) : i0 + 12'(k * 12'h123);
            for (int p = 0; p < 12 / bw; p++) begin
               @(posedge clk_i);
               strobe_o <= !(h == 1 && lo == 0);
               // Unused low bits are held at a fixed high level.
               data_o <= (v << (bw * p)) | (12'hFFF >> bw);
               if (h == 1 && lo > 0) begin
                  repeat (lo) @(posedge clk_i);
                  strobe_o <= 1'b0;
                  repeat (w - 1 - lo) @(posedge clk_i);
               end else begin
                  repeat (w - 1) @(posedge clk_i);
               end
            end
         end
      end
      @(posedge clk_i);
      strobe_o <= 1'b0;
      data_o <= ~data_o;
   endtask
endmodule // iqda_src_model

// >>> tb/iq_input_data_assembler_tb_top.sv
`timescale 1ns/1ns
module iq_input_data_assembler_tb_top;
   import iqda_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic pll = 1'b1;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
   logic strobe;
   logic [11:0] bus, i_d, q_d;
   logic iq_v, ovf, awrdy, wrdy, bv, arrdy, rv;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   int failures = 0, checks = 0, cyc = 0, zc = 0;
   logic [11:0] qi[$], qq[$];
   int qt[$];

   iqda_src_model iqda_src_model_inst (.clk_i(clk), .strobe_o(strobe), .data_o(bus));

   iqda_top iqda_top_inst (
      .CORE_CLK_I(clk), .RST_I(rst), .TX_FRAME_STROBE_I(strobe), .DATA_I(bus), .PLL_LOCKED_I(pll),
      .I_DATA_O(i_d), .Q_DATA_O(q_d), .IQ_VALID_O(iq_v), .OVERFLOW_O(ovf),
      .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awrdy),
      .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wrdy),
      .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(bready),
      .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arrdy),
      .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rready)
   );

   always #10 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;
   // Zero pairs from the idle feed are counted apart from data pairs.
   always @(negedge clk) begin
      if (iq_v === 1'b1) begin
         if ((i_d | q_d) !== 12'h000) begin
            qi.push_back(i_d);
            qq.push_back(q_d);
            qt.push_back(cyc);
         end else begin
            zc++;
         end
      end
   end

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic summarize;
      if (failures == 0 && checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   task automatic wr(input logic [5:0] idx, input logic [31:0] d, input logic [1:0] er);
      bit ah, wh, bh;
      int t;
      logic [1:0] resp;
      ah = 0;
      wh = 0;
      bh = 0;
      t = 0;
      resp = 2'h3;
      @(posedge clk);
      awaddr <= {idx, 2'b00};
      wdata <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      bready <= 1'b1;
      while (!bh && t < 200) begin
         @(negedge clk);
         ah = awv & awrdy;
         wh = wv & wrdy;
         bh = bready & bv;
         resp = bresp;
         t++;
         @(posedge clk);
         if (ah) awv <= 1'b0;
         if (wh) wv <= 1'b0;
         if (bh) bready <= 1'b0;
      end
      chk("bvalid", 32'h0000_0001, 32'(bh));
      chk("bresp", 32'(er), 32'(resp));
   endtask

   task automatic rd(input logic [5:0] idx, input logic [31:0] mask, input logic [31:0] exp,
                     input logic [1:0] er);
      bit ah, rh;
      int t;
      logic [31:0] d;
      logic [1:0] resp;
      ah = 0;
      rh = 0;
      t = 0;
      d = 32'hDEAD_BEEF;
      resp = 2'h3;
      @(posedge clk);
      araddr <= {idx, 2'b00};
      arv <= 1'b1;
      rready <= 1'b1;
      while (!rh && t < 200) begin
         @(negedge clk);
         ah = arv & arrdy;
         rh = rready & rv;
         d = rdata;
         resp = rresp;
         t++;
         @(posedge clk);
         if (ah) arv <= 1'b0;
         if (rh) rready <= 1'b0;
      end
      chk("rvalid", 32'h0000_0001, 32'(rh));
      chk("rdata", exp, d & mask);
      chk("rresp", 32'(er), 32'(resp));
   endtask

   // Sends np pairs and checks their values, order and spacing in core cycles.
   task automatic run(input logic [1:0] fmt, input int w, input int lo, input logic [11:0] i0,
                      input logic [11:0] q0, input int np, input int sp);
      qi.delete();
      qq.delete();
      qt.delete();
      iqda_src_model_inst.send(fmt, w, lo, i0, q0, np);
      repeat (40) @(posedge clk);
      chk("pair count", 32'(np), 32'(qi.size()));
      for (int k = 0; k < qi.size() && k < np; k++) begin
         chk("i sample", 32'(12'(i0 + k * 12'h123)), 32'(qi[k]));
         chk("q sample", 32'(12'(q0 + k * 12'h321)), 32'(qq[k]));
         if (k > 0 && sp > 0) chk("pair spacing", 32'(sp), 32'(qt[k] - qt[k - 1]));
      end
   endtask

   task automatic t_regs;
      rd(IDX_CTRL, 32'hFFFF_FFFF, 32'h0000_0000, RESP_OKAY);
      rd(IDX_HB, 32'hFFFF_FFFF, 32'h0000_0000, RESP_OKAY);
      rd(IDX_FMT, 32'hFFFF_FFFF, 32'h0000_0002, RESP_OKAY);
      rd(IDX_STAT, 32'h0000_0007, 32'h0000_0006, RESP_OKAY);
      rd(6'h10, 32'hFFFF_FFFF, 32'h0000_0000, RESP_SLVERR);
      wr(6'h10, 32'h0000_0001, RESP_SLVERR);
   endtask

   task automatic t_full;
      run(2'b00, 8, -1, 12'h800, 12'h7FF, 3, 16);
      run(2'b00, 8, 1, 12'h123, 12'hF0E, 3, 16);
   endtask

   task automatic t_zero;
      zc = 0;
      repeat (100) @(posedge clk);
      chk("zero pairs", 32'h0000_0001, 32'(zc >= 4));
      chk("idle i", 32'h0000_0000, 32'(i_d));
      rd(IDX_STAT, 32'h0000_0002, 32'h0000_0002, RESP_OKAY);
   endtask

   task automatic t_half;
      wr(IDX_FMT, 32'h0000_0102, RESP_OKAY);
      run(2'b01, 4, -1, 12'hA5C, 12'h3C1, 2, 16);
   endtask

   task automatic t_quarter;
      // The third half-band stage is left enabled here.
      wr(IDX_FMT, 32'h0000_0304, RESP_OKAY);
      run(2'b11, 4, -1, 12'h9E7, 12'h25B, 2, 32);
      wr(IDX_FMT, 32'h0000_0002, RESP_OKAY);
   endtask

   task automatic t_bypass;
      wr(IDX_HB, 32'h0000_0001, RESP_OKAY);
      rd(IDX_HB, 32'hFFFF_FFFF, 32'h0000_0001, RESP_OKAY);
      run(2'b00, 4, -1, 12'h456, 12'hBA9, 2, 8);
      wr(IDX_HB, 32'h0000_0000, RESP_OKAY);
   endtask

   task automatic t_cont;
      // Lock is already up before continuous timing is switched on.
      wr(IDX_CTRL, 32'h0000_0040, RESP_OKAY);
      rd(IDX_CTRL, 32'hFFFF_FFFF, 32'h0000_0040, RESP_OKAY);
      run(2'b00, 8, 0, 12'h321, 12'hCDE, 3, 16);
      repeat (60) @(posedge clk);
      run(2'b00, 8, 0, 12'h6A1, 12'h1F9, 2, 16);
      chk("overflow locked", 32'h0000_0000, 32'(ovf));
   endtask

   task automatic t_ovf;
      pll <= 1'b0;
      run(2'b00, 8, 0, 12'h111, 12'h222, 1, 0);
      chk("overflow set", 32'h0000_0001, 32'(ovf));
      pll <= 1'b1;
      repeat (20) @(posedge clk);
      chk("overflow sticky", 32'h0000_0001, 32'(ovf));
      rd(IDX_STAT, 32'h0000_0001, 32'h0000_0001, RESP_OKAY);
      wr(IDX_CMD, 32'h0000_0001, RESP_OKAY);
      repeat (3) @(posedge clk);
      chk("overflow cleared", 32'h0000_0000, 32'(ovf));
      wr(IDX_CTRL, 32'h0000_0000, RESP_OKAY);
   endtask

   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      t_regs();
      t_full();
      t_zero();
      t_half();
      t_quarter();
      t_bypass();
      t_cont();
      t_ovf();
      summarize();
   end

   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      summarize();
   end
endmodule // iq_input_data_assembler_tb_top
